/* ccpm_pkg.sv */
/*
  Constants for the capture/compare/PWM channel: register offsets, field
  layout, mode codes, prescale terminals and status bit positions.
  Assumes one 32-bit APB slave with word-aligned registers.
*/
package ccpm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CTRL_W = 8;
  localparam int DUTY_HI_W = 8;
  localparam int PT_W = 8;
  ////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_DUTY_HI = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_SHADOW = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CAPT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_CMPV = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_CLR = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_IEN = 8'h1C;
  ////////////////////////////////////////////////////////////////////////
  // control register layout
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  localparam logic [CTRL_W-1:0] CTRL_MASK = 8'h3F;
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 4;
  localparam int DUTY_LSB = 4;
  localparam int DUTY_LO_W = 2;
  ////////////////////////////////////////////////////////////////////////
  // mode codes
  localparam logic [MODE_W-1:0] MODE_OFF = 4'h0;
  localparam logic [MODE_W-1:0] MODE_TOGGLE = 4'h2;
  localparam logic [MODE_W-1:0] MODE_CAP_FALL = 4'h4;
  localparam logic [MODE_W-1:0] MODE_CAP_RISE = 4'h5;
  localparam logic [MODE_W-1:0] MODE_CAP_R4 = 4'h6;
  localparam logic [MODE_W-1:0] MODE_CAP_R16 = 4'h7;
  localparam logic [MODE_W-1:0] MODE_CMP_SET = 4'h8;
  localparam logic [MODE_W-1:0] MODE_CMP_CLR = 4'h9;
  localparam logic [MODE_W-1:0] MODE_CMP_FLAG = 4'hA;
  localparam logic [MODE_W-1:0] MODE_CMP_SPEC = 4'hB;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;
  ////////////////////////////////////////////////////////////////////////
  // prescaler terminals and status bits
  localparam int PRESC_W = 4;
  localparam logic [PRESC_W-1:0] PRESC_ZERO = 4'h0;
  localparam logic [PRESC_W-1:0] PRESC_4 = 4'h3;
  localparam logic [PRESC_W-1:0] PRESC_16 = 4'hF;
  localparam int STAT_W = 2;
  localparam int STAT_EVENT = 0;
  localparam int STAT_RELOAD = 1;
  typedef enum logic [3:0] {
    FUNC_OFF = 4'b0001,
    FUNC_CAP = 4'b0010,
    FUNC_CMP = 4'b0100,
    FUNC_PWM = 4'b1000
  } ccpm_func_e;
endpackage

/* ccpm_channel.sv */
/*
  One capture/compare/PWM channel with its control register, duty
  double buffer, edge prescaler, event flag and APB register slave.
  Assumes the timers live outside: a free capture/compare timer, the
  period timer with its two low time-base bits and a period match pulse.
*/
// Behaviour
// - the two top bits of the channel control register always read as zero.
// - every implemented control bit clears on any reset.
// - mode 0100 captures on each falling pin edge.
// - mode 0101 captures on each rising pin edge.
// - mode 0110 captures on every fourth rising pin edge.
// - mode 0111 captures on every sixteenth rising pin edge.
// - mode 0010 inverts the output at each compare match.
// - mode 1000 drives the output high and sets the event flag on a match.
// - mode 1001 drives the output low and sets the event flag on a match.
// - mode 1010 only sets the event flag on a match, leaving the pin alone.
// - the duty value reaches the shadow and latch only at a period match.
// - in PWM the pin goes low when the time base equals the latched duty.
module ccpm_channel #(
  parameter int TMR_W = 16,
  parameter bit SECOND_CHANNEL = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ccpm_pkg::ADDR_W-1:0] paddr,
  input wire logic [ccpm_pkg::DATA_W-1:0] pwdata,
  output logic [ccpm_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // timers
  input wire logic [TMR_W-1:0] capcomp_timer,
  input wire logic [ccpm_pkg::PT_W-1:0] period_timer,
  input wire logic [ccpm_pkg::DUTY_LO_W-1:0] base_low,
  input wire logic period_match,
  // converter
  input wire logic adc_enabled,
  output logic adc_start,
  // channel pin
  input wire logic channel_pin_in,
  output logic channel_pin_out,
  output logic channel_pin_oe,
  // interrupt
  output logic irq
);
  import ccpm_pkg::*;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [DUTY_HI_W-1:0] duty_high;
    logic [DUTY_HI_W-1:0] shadow;
    logic [DUTY_LO_W-1:0] latch_low;
    logic [TMR_W-1:0] capt;
    logic [TMR_W-1:0] cmpv;
    logic [STAT_W-1:0] stat;
    logic [STAT_W-1:0] ien;
    logic [PRESC_W-1:0] presc;
    logic pin_d;
    logic match_d;
    logic pin_out;
    logic pin_oe;
    logic adc_start;
    logic irq;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } ccpm_state_s;

  localparam ccpm_state_s ST_RST = '0;

  ccpm_state_s cur;
  ccpm_state_s next_st;
  ccpm_func_e func;
  logic [MODE_W-1:0] mode;
  logic rise;
  logic fall;
  logic match_now;
  logic cmp_hit;
  logic cap_ev;
  logic reload_ev;
  logic setup;
  logic access;
  logic [PRESC_W-1:0] presc_top;
  logic [DUTY_HI_W+DUTY_LO_W-1:0] duty_lat;
  logic [DUTY_HI_W+DUTY_LO_W-1:0] duty_new;
  logic [DUTY_HI_W+DUTY_LO_W-1:0] time_base;
  logic [STAT_W-1:0] clr;

  assign mode = cur.ctrl[MODE_LSB +: MODE_W];
  assign duty_lat = {cur.shadow, cur.latch_low};
  assign duty_new = {cur.duty_high, cur.ctrl[DUTY_LSB +: DUTY_LO_W]};
  assign time_base = {period_timer, base_low};
  assign rise = channel_pin_in & ~cur.pin_d;
  assign fall = ~channel_pin_in & cur.pin_d;
  assign match_now = (capcomp_timer == cur.cmpv);
  assign cmp_hit = match_now & ~cur.match_d;
  assign setup = psel & ~penable;
  assign access = psel & penable & cur.pready;
  assign presc_top = (mode == MODE_CAP_R4) ? PRESC_4 : PRESC_16;

  ////////////////////////////////////////////////////////////////////////
  // mode decode
  always_comb begin
    if (mode[MODE_W-1 -: 2] == MODE_PWM_TOP) begin
      func = FUNC_PWM;
    end else if (mode inside {MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_R4, MODE_CAP_R16}) begin
      func = FUNC_CAP;
    end else if (mode == MODE_TOGGLE || mode[MODE_W-1]) begin
      func = FUNC_CMP;
    end else begin
      func = FUNC_OFF;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_st = cur;
    cap_ev = 1'b0;
    reload_ev = 1'b0;
    clr = '0;
    next_st.pin_d = channel_pin_in;
    next_st.match_d = match_now;
    next_st.adc_start = 1'b0;
    case (func)
      FUNC_CAP: begin
        if (mode == MODE_CAP_FALL) begin
          cap_ev = fall;
        end else if (mode == MODE_CAP_RISE) begin
          cap_ev = rise;
        end else if (rise) begin
          if (cur.presc == presc_top) begin
            cap_ev = 1'b1;
            next_st.presc = PRESC_ZERO;
          end else begin
            next_st.presc = cur.presc + 1'b1;
          end
        end
        if (cap_ev) begin
          next_st.capt = capcomp_timer;
        end
      end
      FUNC_CMP: begin
        if (mode == MODE_TOGGLE || mode == MODE_CMP_SET || mode == MODE_CMP_CLR) begin
          next_st.pin_oe = 1'b1;
        end
        if (cmp_hit) begin
          case (mode)
            MODE_TOGGLE: next_st.pin_out = ~cur.pin_out;
            MODE_CMP_SET: next_st.pin_out = 1'b1;
            MODE_CMP_CLR: next_st.pin_out = 1'b0;
            MODE_CMP_SPEC: next_st.adc_start = SECOND_CHANNEL & adc_enabled;
            default: next_st.pin_out = cur.pin_out;
          endcase
        end
      end
      FUNC_PWM: begin
        next_st.pin_oe = 1'b1;
        if (period_match) begin
          next_st.shadow = cur.duty_high;
          next_st.latch_low = cur.ctrl[DUTY_LSB +: DUTY_LO_W];
          next_st.pin_out = (duty_new != '0);
          reload_ev = 1'b1;
        end else if (time_base == duty_lat) begin
          next_st.pin_out = 1'b0;
        end
      end
      default: begin
        // off: prescaler, duty latch and pin back to reset
        next_st.presc = PRESC_ZERO;
        next_st.shadow = '0;
        next_st.latch_low = '0;
        next_st.pin_out = 1'b0;
        next_st.pin_oe = 1'b0;
      end
    endcase

    // apb: answer prepared in setup, given in access
    next_st.pready = setup;
    next_st.pslverr = 1'b0;
    if (setup) begin
      next_st.prdata = '0;
      if (!pwrite) begin
        case (paddr)
          OFF_CTRL: next_st.prdata = DATA_W'(cur.ctrl & CTRL_MASK);
          OFF_DUTY_HI: next_st.prdata = DATA_W'(cur.duty_high);
          OFF_SHADOW: next_st.prdata = DATA_W'(duty_lat);
          OFF_CAPT: next_st.prdata = DATA_W'(cur.capt);
          OFF_CMPV: next_st.prdata = DATA_W'(cur.cmpv);
          OFF_STAT: next_st.prdata = DATA_W'(cur.stat);
          OFF_CLR: next_st.prdata = '0;
          OFF_IEN: next_st.prdata = DATA_W'(cur.ien);
          default: next_st.pslverr = 1'b1;
        endcase
      end else if (!(paddr inside {OFF_CTRL, OFF_DUTY_HI, OFF_CMPV, OFF_CLR, OFF_IEN})) begin
        next_st.pslverr = 1'b1;
      end
    end
    if (access && pwrite && !cur.pslverr) begin
      case (paddr)
        OFF_CTRL: begin
          next_st.ctrl = pwdata[CTRL_W-1:0] & CTRL_MASK;
          if (pwdata[MODE_LSB +: MODE_W] != mode) begin
            next_st.presc = PRESC_ZERO;
          end
        end
        OFF_DUTY_HI: next_st.duty_high = pwdata[DUTY_HI_W-1:0];
        OFF_CMPV: next_st.cmpv = pwdata[TMR_W-1:0];
        OFF_CLR: clr = pwdata[STAT_W-1:0];
        OFF_IEN: next_st.ien = pwdata[STAT_W-1:0];
        default: clr = '0;
      endcase
    end

    // sticky status: a set in the clearing cycle wins
    next_st.stat = cur.stat & ~clr;
    if (cap_ev || (func == FUNC_CMP && cmp_hit)) begin
      next_st.stat[STAT_EVENT] = 1'b1;
    end
    if (reload_ev) begin
      next_st.stat[STAT_RELOAD] = 1'b1;
    end
    next_st.irq = |(next_st.stat & next_st.ien);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur <= ST_RST;
    end else begin
      cur <= next_st;
    end
  end

  assign prdata = cur.prdata;
  assign pready = cur.pready;
  assign pslverr = cur.pslverr;
  assign adc_start = cur.adc_start;
  assign channel_pin_out = cur.pin_out;
  assign channel_pin_oe = cur.pin_oe;
  assign irq = cur.irq;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_ctrl_top_zero: assert property (
    setup && !pwrite && paddr == OFF_CTRL |=> pready && prdata[7:6] == 2'b00)
    else $error("control top bits not zero");
  chk_reset_clear: assert property (
    $past(sys_rst) |-> cur.ctrl == CTRL_RST && !channel_pin_oe && !irq)
    else $error("state not cleared by reset");
  chk_duty_low_load: assert property (
    func == FUNC_PWM && period_match |=> cur.latch_low == $past(cur.ctrl[DUTY_LSB +: DUTY_LO_W]))
    else $error("duty low bits not latched");
  chk_cap_falling: assert property (
    mode == MODE_CAP_FALL && fall |=> cur.capt == $past(capcomp_timer) && cur.stat[STAT_EVENT])
    else $error("falling edge capture missed");
  chk_cap_rising: assert property (
    mode == MODE_CAP_RISE && rise |=> cur.capt == $past(capcomp_timer) && cur.stat[STAT_EVENT])
    else $error("rising edge capture missed");
  chk_cap_quarter: assert property (
    mode == MODE_CAP_R4 && rise && cur.presc != PRESC_4 |=> $stable(cur.capt))
    else $error("capture before fourth edge");
  chk_cap_sixteenth: assert property (
    mode == MODE_CAP_R16 && rise && cur.presc == PRESC_16 |=> cur.capt == $past(capcomp_timer))
    else $error("sixteenth edge capture missed");
  chk_cmp_toggle: assert property (
    func == FUNC_CMP && mode == MODE_TOGGLE && cmp_hit |=> channel_pin_out != $past(channel_pin_out))
    else $error("toggle on match missed");
  chk_cmp_set: assert property (
    mode == MODE_CMP_SET && cmp_hit |=> channel_pin_out && channel_pin_oe && cur.stat[STAT_EVENT])
    else $error("set on match missed");
  chk_cmp_clear: assert property (
    mode == MODE_CMP_CLR && cmp_hit |=> !channel_pin_out && channel_pin_oe && cur.stat[STAT_EVENT])
    else $error("clear on match missed");
  chk_cmp_flag_only: assert property (
    mode == MODE_CMP_FLAG && cmp_hit |=> $stable(channel_pin_out) && cur.stat[STAT_EVENT])
    else $error("flag-only match touched pin");
  chk_special_adc: assert property (
    mode == MODE_CMP_SPEC && cmp_hit |=> adc_start == (SECOND_CHANNEL && $past(adc_enabled)))
    else $error("special event trigger wrong");
  chk_mode_off: assert property (
    mode == MODE_OFF |=> !channel_pin_oe && !channel_pin_out && cur.presc == PRESC_ZERO)
    else $error("off mode left state");
  chk_pwm_decode: assert property (
    mode[MODE_W-1 -: 2] == MODE_PWM_TOP |=> channel_pin_oe)
    else $error("pwm not selected");
  chk_shadow_hold: assert property (
    func == FUNC_PWM && !period_match |=> $stable(cur.shadow) && $stable(cur.latch_low))
    else $error("duty loaded outside period match");
  chk_pwm_clear: assert property (
    func == FUNC_PWM && !period_match && time_base == duty_lat |=> !channel_pin_out)
    else $error("pwm pin not cleared at duty");

  cov_cap_r4: cover property (mode == MODE_CAP_R4 && rise && cur.presc == PRESC_4);
  cov_pwm_cycle: cover property (func == FUNC_PWM && period_match ##[1:600] !channel_pin_out);
  cov_irq: cover property (mode == MODE_CMP_SET && cmp_hit ##[1:4] irq);
endmodule

/* ccpm_pin_model.sv */
/*
  Far-side model of the channel pin: an external source that drives the
  line while the channel leaves it undriven.
  Assumes the channel samples the pin synchronously on clk.
*/
module ccpm_pin_model (
  // clock
  input wire logic clk,
  // channel pin, device side
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ext_level = 1'b0;
  // source steps back while the channel drives
  assign pin_in = pin_oe ? pin_out : ext_level;
  ////////////////////////////////////////////////////////////////////////
  // new level after an edge, held for settle cycles
  task automatic set_level(input logic v, input int settle);
    @(posedge clk);
    ext_level <= v;
    repeat (settle) @(posedge clk);
  endtask
endmodule

/* tb_top.sv */
/*
  Self-checking bench for one capture/compare/PWM channel.
  Assumes the channel is the conversion-trigger owner and answers APB.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ccpm_pkg::*;
  logic clk, sys_rst, psel, penable, pwrite, pmatch, adc_en, pready, pslverr, adc_start, pin_in, pin_out, pin_oe, irq;
  logic [7:0] paddr, ptmr;
  logic [31:0] pwdata, prdata;
  logic [15:0] tmr;
  logic [1:0] blow;
  int n_mismatch = 0, checks = 0, adc_cnt = 0;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} ccpm_row_s;
  ccpm_row_s rows [8] = '{'{OFF_CTRL, 32'h000000FF, 32'h0000003F, 1'b0}, '{OFF_DUTY_HI, 32'h000001A5, 32'h000000A5, 1'b0},
    '{OFF_CMPV, 32'hFFFF1234, 32'h00001234, 1'b0}, '{OFF_IEN, 32'h0000000F, 32'h00000003, 1'b0},
    '{OFF_CLR, 32'h00000003, 32'h00000000, 1'b0}, '{OFF_STAT, 32'h000000FF, 32'h00000000, 1'b0},
    '{OFF_SHADOW, 32'h000003FF, 32'h00000000, 1'b0}, '{8'h20, 32'h00000005, 32'h00000000, 1'b1}};
  logic [3:0] cm [7] = '{4'h8, 4'h9, 4'h2, 4'h2, 4'hA, 4'hB, 4'hB};
  logic co [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  logic ca [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  int cn [7] = '{0, 0, 0, 0, 0, 1, 1};
  ccpm_channel #(.TMR_W(16), .SECOND_CHANNEL(1'b1)) ccpm_channel_i (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capcomp_timer(tmr), .period_timer(ptmr), .base_low(blow), .period_match(pmatch),
    .adc_enabled(adc_en), .adc_start(adc_start), .channel_pin_in(pin_in), .channel_pin_out(pin_out),
    .channel_pin_oe(pin_oe), .irq(irq));
  ccpm_pin_model ccpm_pin_model_i (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (adc_start === 1'b1) adc_cnt++;
  end
  task automatic report_and_stop();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) check("pready", 32'h0, 32'h1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(name, r, x);
  endtask
  task automatic pin_edge(input logic v, input logic [15:0] t);
    @(posedge clk);
    tmr <= t;
    ccpm_pin_model_i.set_level(v, 3);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    logic [31:0] r;
    logic e;
    logic [3:0] m;
    logic [9:0] dn, dold;
    int n;
    {sys_rst, psel, penable, pwrite, paddr, pwdata, tmr, ptmr, blow, pmatch, adc_en} = '0;
    sys_rst = 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    // register table: reset value, write, read back
    foreach (rows[i]) begin
      rdc("reset_value", rows[i].a, 32'h0);
      wr(rows[i].a, rows[i].w);
      apb(1'b0, rows[i].a, 32'h0, r, e);
      check("reg_read", r, rows[i].r);
      check("reg_err", {31'h0, e}, {31'h0, rows[i].e});
    end
    wr(OFF_CTRL, 32'h0);
    // capture modes, prescaled counts
    for (int k = 0; k < 4; k++) begin
      m = MODE_CAP_FALL + 4'(k);
      n = (k == 2) ? 4 : (k == 3) ? 16 : 1;
      wr(OFF_CLR, 32'h3);
      wr(OFF_CTRL, {28'h0, m});
      for (int i = 1; i < n; i++) begin
        pin_edge(1'b1, 16'h0100);
        pin_edge(1'b0, 16'h0200);
      end
      rdc("stat_early", OFF_STAT, 32'h0);
      pin_edge(1'b1, 16'hA000 + 16'(k));
      rdc("stat_rise", OFF_STAT, (k == 0) ? 32'h0 : 32'h1);
      pin_edge(1'b0, 16'hB000 + 16'(k));
      rdc("capt", OFF_CAPT, 32'((k == 0) ? 16'hB000 + 16'(k) : 16'hA000 + 16'(k)));
      check("irq", {31'h0, irq}, 32'h1);
    end
    wr(OFF_CLR, 32'h3);
    @(negedge clk);
    check("irq_clear", {31'h0, irq}, 32'h0);
    // compare modes, masked interrupt
    wr(OFF_IEN, 32'h0);
    wr(OFF_CMPV, 32'h50);
    for (int k = 0; k < 7; k++) begin
      wr(OFF_CLR, 32'h3);
      wr(OFF_CTRL, {28'h0, cm[k]});
      @(posedge clk);
      {adc_en, tmr} <= {ca[k], 16'h0};
      repeat (2) @(posedge clk);
      tmr <= 16'h0050;
      repeat (3) @(posedge clk);
      tmr <= 16'h0;
      @(negedge clk);
      check("cmp_pin", {31'h0, pin_out}, {31'h0, co[k]});
      check("cmp_oe", {31'h0, pin_oe}, 32'h1);
      check("irq_masked", {31'h0, irq}, 32'h0);
      check("adc_starts", 32'(adc_cnt), 32'(cn[k]));
      rdc("cmp_flag", OFF_STAT, 32'h1);
    end
    // pwm with double-buffered duty
    for (int p = 0; p < 2; p++) begin
      dn = p ? 10'h00E : 10'h009;
      dold = p ? 10'h009 : 10'h000;
      wr(OFF_DUTY_HI, {24'h0, dn[9:2]});
      wr(OFF_CTRL, {26'h0, dn[1:0], p ? 4'hF : 4'hC});
      rdc("shadow_hold", OFF_SHADOW, {22'h0, dold});
      @(posedge clk);
      pmatch <= 1'b1;
      @(posedge clk);
      pmatch <= 1'b0;
      {ptmr, blow} <= dn - 10'h1;
      repeat (2) @(negedge clk);
      check("pwm_set", {31'h0, pin_out}, 32'h1);
      rdc("shadow_load", OFF_SHADOW, {22'h0, dn});
      @(posedge clk);
      {ptmr, blow} <= dn;
      repeat (2) @(negedge clk);
      check("pwm_clear", {31'h0, pin_out}, 32'h0);
    end
    wr(OFF_CTRL, 32'h0);
    // off mode is decoded from the registered field, so pin_oe clears one edge after the write
    repeat (2) @(negedge clk);
    check("off_oe", {31'h0, pin_oe}, 32'h0);
    // reset in mid-run
    wr(OFF_CTRL, 32'h25);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rdc("ctrl_rerst", OFF_CTRL, 32'h0);
    report_and_stop();
  end
endmodule
